// >>> logic/mks_unit.sv
`timescale 1ns/1ps
`include "mks_consts.svh"
// Function
// (RULE1) compare sets flag 53 equal, 54 greater, 55 less
// (RULE2) key element i meets reference element start plus i ascending
// (RULE3) whole key within threshold gives match and ends at once
// (RULE4) failed attempt restarts one reference element to the right
// (RULE5) at most reference minus key plus one attempts without match
// (RULE6) no match sets select-condition-not-met flag 37
// (RULE7) reference index plus one per failure, full length if no match
// (RULE8) match leaves index at matched start, key index unchanged
// (RULE9) only mask-one bit positions are compared
// (RULE10) mask is key length and element i masks key element i
// (RULE11) zero mask designator means mask of all ones
// (RULE12) issuer avoids zero designators, zero lengths, key longer than ref
// (RULE13) up to threshold differences tolerated per attempt
// (RULE14) threshold is low 16 bits of designated register
// (RULE15) word variant compares words on word boundaries
// (RULE16) bit variant compares bits on every bit boundary
// (RULE17) difference counter cleared at each attempt start
// (RULE18) compare inequality advances enabled indexes by prior compares
module mks_unit
  import mks_pkg::*;
(
  input  wire                   mclk,      // processor clock
  input  wire                   nrst,      // sync reset, active low
  input  wire                   start,     // one-cycle issue pulse
  input  wire mks_cmd_s         cmd,       // decoded instruction fields
  input  wire [63:0]            thr_reg,   // threshold register contents
  output logic                  busy,      // instruction in progress
  output logic                  elem_req,  // element fetch request
  output logic [`MKS_LEN_W-1:0] ref_pos,   // reference element position
  output logic [`MKS_LEN_W-1:0] key_pos,   // key and mask position
  input  wire                   elem_vld,  // fetched element valid
  input  wire mks_elem_s        elem,      // fetched elements
  output logic                  done,      // one-cycle completion pulse
  output mks_res_s              res        // results, held until next
);
  mks_state_e             st_r, st_nxt;
  mks_cmd_s               cmd_r, cmd_nxt;
  logic [`MKS_LEN_W-1:0]  start_r, start_nxt;
  logic [`MKS_LEN_W-1:0]  i_r, i_nxt;
  logic [`MKS_THR_W-1:0]  diff_r, diff_nxt;
  logic [`MKS_LEN_W-1:0]  tries_r, tries_nxt;
  mks_res_s               res_r, res_nxt;
  logic                   differ;
  logic                   a_gt;
  logic                   is_cmp;
  logic [`MKS_LEN_W-1:0]  max_tries;
  logic [`MKS_LEN_W-1:0]  cmp_len;

  function automatic logic [`MKS_LEN_W-1:0] inc1(
    input logic [`MKS_LEN_W-1:0] v
  );
    inc1 = v + `MKS_ONE_LEN;
  endfunction

  mks_elem_cmp u_cmp (
    .op        (cmd_r.op),
    .mask_zero (cmd_r.mask_zero),
    .elem      (elem),
    .differ    (differ),
    .a_gt      (a_gt)
  );

  assign is_cmp = (cmd_r.op == MKS_OP_CMP);
  // (RULE5) attempt limit
  assign max_tries = cmd_r.len_a - cmd_r.len_b + `MKS_ONE_LEN;
  assign cmp_len = (cmd_r.len_a > cmd_r.len_b) ? cmd_r.len_a : cmd_r.len_b;
  assign busy = (st_r != MKS_ST_IDLE);
  assign elem_req = (st_r == MKS_ST_REQ);
  // (RULE2) reference element at start plus i
  assign ref_pos = is_cmp ? i_r : (start_r + i_r);
  // (RULE10) mask element follows key element
  assign key_pos = i_r;
  assign done = (st_r == MKS_ST_DONE);
  assign res = res_r;

  always_comb begin
    st_nxt = st_r;
    cmd_nxt = cmd_r;
    start_nxt = start_r;
    i_nxt = i_r;
    diff_nxt = diff_r;
    tries_nxt = tries_r;
    res_nxt = res_r;
    case (st_r)
      MKS_ST_IDLE: begin
        if (start) begin
          cmd_nxt = cmd;
          // (RULE14) low 16 threshold bits
          cmd_nxt.thresh = thr_reg[`MKS_THR_W-1:0];
          start_nxt = `MKS_ZERO_LEN;
          i_nxt = `MKS_ZERO_LEN;
          diff_nxt = {`MKS_THR_W{1'b0}};
          tries_nxt = `MKS_ONE_LEN;
          res_nxt = '0;
          st_nxt = MKS_ST_REQ;
        end
      end
      MKS_ST_REQ: begin
        st_nxt = MKS_ST_WAIT;
      end
      MKS_ST_WAIT: begin
        if (elem_vld) begin
          if (is_cmp) begin
            if (differ) begin
              // (RULE1) inequality flags
              res_nxt.flag_gt = a_gt;
              res_nxt.flag_lt = !a_gt;
              // (RULE18) partial increment
              res_nxt.inc_a = cmd_r.inc_a_en ? i_r : `MKS_ZERO_LEN;
              res_nxt.inc_b = cmd_r.inc_b_en ? i_r : `MKS_ZERO_LEN;
              st_nxt = MKS_ST_DONE;
            end else if (inc1(i_r) >= cmp_len) begin
              // (RULE1) equal flag, full increment
              res_nxt.flag_eq = 1'b1;
              res_nxt.inc_a = cmd_r.inc_a_en ? cmd_r.len_a : `MKS_ZERO_LEN;
              res_nxt.inc_b = cmd_r.inc_b_en ? cmd_r.len_b : `MKS_ZERO_LEN;
              st_nxt = MKS_ST_DONE;
            end else begin
              i_nxt = inc1(i_r);
              st_nxt = MKS_ST_REQ;
            end
          end else if (differ && (diff_r >= cmd_r.thresh)) begin
            // (RULE13) differences exceed threshold
            st_nxt = MKS_ST_NEXT;
          end else if (inc1(i_r) >= cmd_r.len_b) begin
            // (RULE3) match ends instruction
            res_nxt.matched = 1'b1;
            // (RULE8) partial index, key index untouched
            res_nxt.inc_a = start_r;
            res_nxt.inc_b = `MKS_ZERO_LEN;
            st_nxt = MKS_ST_DONE;
          end else begin
            if (differ) begin
              diff_nxt = diff_r + 16'h0001;
            end
            i_nxt = inc1(i_r);
            st_nxt = MKS_ST_REQ;
          end
        end
      end
      MKS_ST_NEXT: begin
        if (tries_r >= max_tries) begin
          // (RULE6) no match flag
          res_nxt.flag_nomatch = 1'b1;
          // (RULE7) full reference length
          res_nxt.inc_a = cmd_r.len_a;
          res_nxt.inc_b = `MKS_ZERO_LEN;
          st_nxt = MKS_ST_DONE;
        end else begin
          // (RULE4) shift start right one element
          start_nxt = inc1(start_r);
          tries_nxt = inc1(tries_r);
          i_nxt = `MKS_ZERO_LEN;
          // (RULE17) fresh difference count
          diff_nxt = {`MKS_THR_W{1'b0}};
          st_nxt = MKS_ST_REQ;
        end
      end
      MKS_ST_DONE: begin
        st_nxt = MKS_ST_IDLE;
      end
      default: begin
        st_nxt = MKS_ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge mclk) begin
    if (!nrst) begin
      st_r <= MKS_ST_IDLE;
      cmd_r <= '0;
      start_r <= `MKS_ZERO_LEN;
      i_r <= `MKS_ZERO_LEN;
      diff_r <= {`MKS_THR_W{1'b0}};
      tries_r <= `MKS_ZERO_LEN;
      res_r <= '0;
    end else begin
      st_r <= st_nxt;
      cmd_r <= cmd_nxt;
      start_r <= start_nxt;
      i_r <= i_nxt;
      diff_r <= diff_nxt;
      tries_r <= tries_nxt;
      res_r <= res_nxt;
    end
  end
endmodule

// >>> logic/mks_consts.svh
`ifndef MKS_CONSTS_SVH
`define MKS_CONSTS_SVH
`define MKS_FLAG_EQ      6'd53
`define MKS_FLAG_GT      6'd54
`define MKS_FLAG_LT      6'd55
`define MKS_FLAG_NOMATCH 6'd37
`define MKS_THR_W        16
`define MKS_LEN_W        16
`define MKS_ELEM_W       64
`define MKS_MASK_ONES    64'hffffffffffffffff
`define MKS_ZERO_LEN     16'h0000
`define MKS_ONE_LEN      16'h0001
`endif

// >>> logic/mks_pkg.sv
`include "mks_consts.svh"
package mks_pkg;
  typedef enum logic [1:0] {
    MKS_OP_BYTE = 2'h0,
    MKS_OP_WORD = 2'h1,
    MKS_OP_BIT  = 2'h2,
    MKS_OP_CMP  = 2'h3
  } mks_op_e;

  typedef enum logic [4:0] {
    MKS_ST_IDLE = 5'h01,
    MKS_ST_REQ  = 5'h02,
    MKS_ST_WAIT = 5'h04,
    MKS_ST_NEXT = 5'h08,
    MKS_ST_DONE = 5'h10
  } mks_state_e;

  typedef struct packed {
    mks_op_e                   op;
    logic                      mask_zero;
    logic [`MKS_LEN_W-1:0]     len_a;
    logic [`MKS_LEN_W-1:0]     len_b;
    logic [`MKS_THR_W-1:0]     thresh;
    logic                      inc_a_en;
    logic                      inc_b_en;
  } mks_cmd_s;

  typedef struct packed {
    logic [`MKS_ELEM_W-1:0] a;
    logic [`MKS_ELEM_W-1:0] b;
    logic [`MKS_ELEM_W-1:0] m;
  } mks_elem_s;

  typedef struct packed {
    logic                  matched;
    logic [`MKS_LEN_W-1:0] inc_a;
    logic [`MKS_LEN_W-1:0] inc_b;
    logic                  flag_eq;
    logic                  flag_gt;
    logic                  flag_lt;
    logic                  flag_nomatch;
  } mks_res_s;
endpackage

// >>> logic/mks_elem_cmp.sv
`timescale 1ns/1ps
`include "mks_consts.svh"
module mks_elem_cmp
  import mks_pkg::*;
(
  input  wire mks_op_e   op,        // granularity of compare
  input  wire            mask_zero, // mask designator was zero
  input  wire mks_elem_s elem,      // reference, key, mask element
  output logic           differ,    // masked difference
  output logic           a_gt       // masked reference greater
);
  logic [`MKS_ELEM_W-1:0] m;
  logic [`MKS_ELEM_W-1:0] ma;
  logic [`MKS_ELEM_W-1:0] mb;

  always_comb begin
    // (RULE11) all-ones mask
    m = mask_zero ? `MKS_MASK_ONES : elem.m;
    // (RULE15) word compares full width; bytes and bits use low lanes
    case (op)
      MKS_OP_WORD: m = m;
      // (RULE16) single bit compare
      MKS_OP_BIT:  m = {63'h0, m[0]};
      default:     m = {56'h0, m[7:0]};
    endcase
    // (RULE9) only mask-one bits compared
    ma = elem.a & m;
    mb = elem.b & m;
    differ = (ma != mb);
    a_gt = (ma > mb);
  end
endmodule

// >>> dv/mks_unit_checker.sv
`timescale 1ns/1ps
module mks_unit_checker
  import mks_pkg::*;
(
  input wire            mclk,     // clock
  input wire            nrst,     // sync reset
  input wire            start,    // issue pulse
  input wire mks_cmd_s  cmd,      // fields
  input wire [63:0]     thr_reg,  // threshold
  input wire            busy,     // busy
  input wire            elem_req, // fetch
  input wire [15:0]     ref_pos,  // ref position
  input wire [15:0]     key_pos,  // key position
  input wire            elem_vld, // valid
  input wire mks_elem_s elem,     // elements
  input wire            done,     // done pulse
  input wire mks_res_s  res       // results
);
  logic [15:0] la_r;
  logic [15:0] rp_r;
  logic [15:0] kp_r;
  mks_op_e     op_r;
  logic        first_r;
  wire         srch = op_r != MKS_OP_CMP;
  always_ff @(posedge mclk) begin
    if (start && !busy) begin
      la_r <= cmd.len_a;
      op_r <= cmd.op;
    end
    if (elem_req) begin
      rp_r <= ref_pos;
      kp_r <= key_pos;
    end
    // first fetch of an instruction is not a restart
    first_r <= nrst && (start && !busy || first_r && !elem_req);
  end
  default clocking @(posedge mclk); endclocking
  default disable iff (!nrst);
  a_first_fetch: assert property (start && !busy |=> elem_req && busy
    && ref_pos == 16'h0000 && key_pos == 16'h0000) else $error("first fetch");
  a_key_step: assert property (elem_req && key_pos != 16'h0000
    |-> key_pos == kp_r + 16'h0001 && ref_pos == rp_r + 16'h0001)
    else $error("step not ascending");
  a_restart_right: assert property (elem_req && !first_r
    && key_pos == 16'h0000 |-> ref_pos == rp_r - kp_r + 16'h0001)
    else $error("restart position");
  a_attempt_bound: assert property (elem_req && srch
    |-> ref_pos < la_r) else $error("fetch past reference");
  a_nomatch_flag: assert property (done && srch && !res.matched
    |-> res.flag_nomatch && res.inc_a == la_r) else $error("no match");
  a_match_index: assert property (done && srch && res.matched
    |-> res.inc_a == rp_r - kp_r && res.inc_b == 16'h0000
    && !res.flag_nomatch) else $error("match index");
  a_cmp_flags: assert property (done && !srch
    |-> $onehot({res.flag_eq, res.flag_gt, res.flag_lt}))
    else $error("compare flags");
  a_done_pulse: assert property (done |=> !done) else $error("done");
  a_req_pulse: assert property (elem_req |=> !elem_req) else $error("req");
endmodule

bind mks_unit mks_unit_checker i_chk (.mclk(mclk), .nrst(nrst),
  .start(start), .cmd(cmd), .thr_reg(thr_reg), .busy(busy),
  .elem_req(elem_req), .ref_pos(ref_pos), .key_pos(key_pos),
  .elem_vld(elem_vld), .elem(elem), .done(done), .res(res));

// >>> dv/mks_mem_model.sv
`timescale 1ns/1ps
module mks_mem_model
  import mks_pkg::*;
(
  input  wire         mclk,     // clock
  input  wire         nrst,     // sync reset
  input  wire         elem_req, // fetch request
  input  wire [15:0]  ref_pos,  // ref element
  input  wire [15:0]  key_pos,  // key element
  input  logic [63:0] ra [8],   // reference field
  input  logic [63:0] kb [8],   // key field
  input  logic [63:0] mc [8],   // mask field
  output logic        elem_vld, // valid
  output mks_elem_s   elem      // elements
);
  logic [2:0] rp;
  logic [2:0] kp;
  logic [1:0] cnt;
  logic       slow;
  // mask follows key
  // inverted outside valid so a stray sample misses
  assign elem = elem_vld ? {ra[rp], kb[kp], mc[kp]}
                         : ~{ra[rp], kb[kp], mc[kp]};
  always @(posedge mclk) begin
    elem_vld <= 1'b0;
    if (!nrst) begin
      cnt <= 2'h0;
      slow <= 1'b0;
    end else if (elem_req) begin
      rp <= ref_pos[2:0];
      kp <= key_pos[2:0];
      cnt <= slow ? 2'h3 : 2'h1;
      slow <= ~slow;
    end else if (cnt != 2'h0) begin
      cnt <= cnt - 2'h1;
      elem_vld <= cnt == 2'h1;
    end
  end
endmodule

// >>> dv/mks_unit_tb.sv
`timescale 1ns/1ps
module mks_unit_tb
  import mks_pkg::*;
;
  logic        mclk = 1'b0;
  logic        nrst = 1'b0;
  logic        start = 1'b0;
  mks_cmd_s    cmd = '0;
  logic [63:0] thr_reg = '0;
  logic [63:0] ra [8];
  logic [63:0] kb [8];
  logic [63:0] mc [8];
  logic        busy, elem_req, elem_vld, done;
  logic [15:0] ref_pos, key_pos;
  mks_elem_s   elem;
  mks_res_s    res;
  int          err_count = 0;
  int          checks = 0;
  always #25 mclk = ~mclk;
  mks_unit i_dut (.mclk(mclk), .nrst(nrst), .start(start), .cmd(cmd),
    .thr_reg(thr_reg), .busy(busy), .elem_req(elem_req),
    .ref_pos(ref_pos), .key_pos(key_pos), .elem_vld(elem_vld),
    .elem(elem), .done(done), .res(res));
  mks_mem_model i_mem (.mclk(mclk), .nrst(nrst), .elem_req(elem_req),
    .ref_pos(ref_pos), .key_pos(key_pos), .ra(ra), .kb(kb), .mc(mc),
    .elem_vld(elem_vld), .elem(elem));
  task automatic final_report;
    $display("checks %0d errors %0d", checks, err_count);
    if (err_count == 0 && checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task automatic chk(string nm, logic [36:0] e, logic [36:0] g);
    checks++;
    if (g !== e) begin
      err_count++;
      $display("ERROR %s exp %h got %h", nm, e, g);
    end
  endtask
  task automatic run(string nm, mks_op_e op, logic mz, logic [15:0] th,
                     logic [1:0] en, logic [36:0] e);
    int n;
    logic [36:0] g;
    n = 0;
    @(posedge mclk);
    cmd <= '{op, mz, (op == MKS_OP_CMP) ? 16'h0003 : 16'h0006,
             16'h0003, 16'h0000, en[1], en[0]};
    thr_reg <= {48'habcd0000ffff, th};
    start <= 1'b1;
    @(posedge mclk);
    start <= 1'b0;
    while (done !== 1'b1 && n < 400) begin
      @(posedge mclk);
      #1;
      n++;
    end
    // a hung instruction is a mismatch even if stale results agree
    if (n >= 400) begin
      err_count++;
      $display("ERROR %s done exp 1 got 0", nm);
    end
    g = {res.matched, res.flag_eq, res.flag_gt, res.flag_lt,
         res.flag_nomatch, res.inc_a, res.inc_b};
    // flags of the other instruction kind are left open
    if (op == MKS_OP_CMP) {g[36], g[32]} = {e[36], e[32]};
    else g[35:33] = e[35:33];
    chk(nm, e, g);
    $display("test %s done", nm);
  endtask
  initial begin
    ra = '{64'h11, 64'h20, 64'h30, 64'h110, 64'h20, 64'h40, 64'h0, 64'h0};
    kb = '{0: 64'h10, 1: 64'h20, 2: 64'h40, default: 64'h0};
    mc = '{0: 64'hf0, 1: 64'hff, 2: 64'h0f, default: 64'h0};
    repeat (3) @(posedge mclk);
    nrst <= 1'b1;
    // nonzero lengths, key not longer than reference
    run("byte", MKS_OP_BYTE, 1'b1, 16'h0000, 2'h3, {5'h10, 16'h3, 16'h0});
    run("thr1", MKS_OP_BYTE, 1'b1, 16'h0001, 2'h3, {5'h10, 16'h3, 16'h0});
    run("thr2", MKS_OP_BYTE, 1'b1, 16'h0002, 2'h3, {5'h10, 16'h0, 16'h0});
    run("mask", MKS_OP_BYTE, 1'b0, 16'h0000, 2'h3, {5'h10, 16'h0, 16'h0});
    run("word", MKS_OP_WORD, 1'b1, 16'h0000, 2'h3, {5'h01, 16'h6, 16'h0});
    run("bit", MKS_OP_BIT, 1'b1, 16'h0000, 2'h3, {5'h10, 16'h1, 16'h0});
    run("cmp_eq", MKS_OP_CMP, 1'b0, 16'h0, 2'h3, {5'h08, 16'h3, 16'h3});
    run("cmp_gt", MKS_OP_CMP, 1'b1, 16'h0, 2'h3, {5'h04, 16'h0, 16'h0});
    ra[0] = 64'h10;
    run("cmp_lt", MKS_OP_CMP, 1'b1, 16'h0, 2'h2, {5'h02, 16'h2, 16'h0});
    final_report;
  end
  initial begin
    #1000000;
    err_count++;
    final_report;
  end
endmodule
